// *** ilc_core_model.sv ***
`timescale 1ns/1ns
module ilc_core_model
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       hw_vector_call,
   input  wire logic       call_busy,
   input  wire logic       stall,
   input  wire logic       cfg_wr,
   input  wire logic [7:0] svc_len,
   output logic            core_last_cycle,
   output logic            core_cfg_write,
   output logic            core_reti
);
   logic [3:0] depth_q;
   logic [7:0] cnt_q;
   assign core_last_cycle = !stall;
   assign core_cfg_write  = cfg_wr;
   // returns in nesting order; a nested call restarts the timer
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         depth_q   <= 4'h0;
         cnt_q     <= 8'h00;
         core_reti <= 1'b0;
      end
      else
      begin
         core_reti <= 1'b0;
         if (hw_vector_call)
         begin
            depth_q <= depth_q + 4'h1;
            cnt_q   <= 8'h00;
         end
         else if (depth_q != 4'h0 && !call_busy && !core_reti)
         begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q >= svc_len)
            begin
               core_reti <= 1'b1;
               depth_q   <= depth_q - 4'h1;
               cnt_q     <= 8'h00;
            end
         end
      end
endmodule

// *** ilc_defs.svh ***
// Operation
// - Thirteen sources, four levels, one global enable
// - External pins edge or level per bit
// - Edge mode: high then low sample sets
// - Edge flag cleared on vectored entry
// - Level flag follows pin, never auto-cleared
// - Timer overflow flags cleared when serviced
// - Serial done flags cleared by software only
// - Watchdog flag set on time-out, gated
// - Conversion-done flag held until software clears
// - Comparator toggle flags, software clear only
// - Two-wire flag needs port and global enable
// - Brake flag raises PWM request, software clear
// - Software may set or clear every flag; level-mode pin flags take only a one-clock set
// - Per-source enables plus global block
// - Sample, poll and resolve each machine cycle
// - Call only above current in-service level
// - Call on last cycle, not config writes
// - Pins sampled at C3, polled next cycle
// - Vectored call lasts four machine cycles
// - Worst response twelve machine cycles
// - Fixed vectors, fixed tie ranking, PWM lowest
// - Serial shares vector and enable, no wakeup
// - Conversion wakeup only with internal RC clock
`ifndef ILC_DEFS_SVH
`define ILC_DEFS_SVH

`define ILC_NSRC          13
`define ILC_NFLAG         14

// APB byte offsets
`define ILC_OFF_FLAG      12'h000
`define ILC_OFF_ENABLE    12'h004
`define ILC_OFF_PRIO_LO   12'h008
`define ILC_OFF_PRIO_HI   12'h00c
`define ILC_OFF_CTRL      12'h010
`define ILC_OFF_STATUS    12'h014

// Field positions
`define ILC_EA_BIT        15
`define ILC_CTRL_IT0      0
`define ILC_CTRL_IT1      1
`define ILC_CTRL_ADC_RC   2
`define ILC_TX_FLAG_BIT   13

// Source indices, index order is arbitration rank
`define ILC_SRC_EXT0      0
`define ILC_SRC_TMR0      5
`define ILC_SRC_EXT1      6
`define ILC_SRC_ADC       3
`define ILC_SRC_TMR1      9
`define ILC_SRC_SER       11

// Reset values
`define ILC_RST_FLAG      14'h0000
`define ILC_RST_EN        13'h0000
`define ILC_RST_PRIO      13'h0000
`define ILC_RST_CTRL      3'h0

// Timing
`define ILC_CLKS_PER_MC   4
`define ILC_C3_PHASE      2'h2
`define ILC_C4_PHASE      2'h3
`define ILC_CALL_MC       4
`define ILC_CALL_CLKS     (`ILC_CALL_MC * `ILC_CLKS_PER_MC)

// Wakeup capable sources; conversion bit gated at run time
`define ILC_WAKE_MASK     13'h05d7

// Vectors by source index
`define ILC_VEC_TABLE { 16'h0073, 16'h0023, 16'h0043, 16'h001b, \
   16'h0063, 16'h003b, 16'h0013, 16'h000b, 16'h0053, 16'h005b, \
   16'h0033, 16'h004b, 16'h0003 }

`endif

// *** ilc_ext_sampler.sv ***
`timescale 1ns/1ns
`include "ilc_defs.svh"
module ilc_ext_sampler
   import ilc_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pin,
   input  wire logic c3_strobe,
   input  wire logic trigger_type,
   input  wire logic sw_we,
   input  wire logic sw_val,
   input  wire logic hw_ack,
   output logic      ext_request_flag
);
   typedef struct packed {
      logic smp;
      logic flag;
   } ilc_smp_s;

   ilc_smp_s q;
   ilc_smp_s d;

   always_comb
   begin
      d = q;
      if (c3_strobe)
      begin
         d.smp = pin;
      end
      if (trigger_type)
      begin
         if (sw_we)
         begin
            d.flag = sw_val;
         end
         else if (hw_ack)
         begin
            d.flag = 1'b0;
         end
         // high-then-low sets; set beats any clear
         if (c3_strobe && q.smp && !pin)
         begin
            d.flag = 1'b1;
         end
      end
      else
      begin
         d.flag = ~d.smp;
         if (sw_we && sw_val)
         begin
            d.flag = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q <= '{smp: 1'b1, flag: 1'b0};
      end
      else
      begin
         q <= d;
      end
   end

   assign ext_request_flag = q.flag;
endmodule

// *** ilc_irq_ctrl.sv ***
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "ilc_defs.svh"
module ilc_irq_ctrl
   import ilc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_irq_pin0,
   input  wire logic        ext_irq_pin1,
   input  wire logic        bod_event,
   input  wire logic        twi_status_event,
   input  wire logic        conv_done_event,
   input  wire logic        wdog_timeout_event,
   input  wire logic        timer0_overflow_event,
   input  wire logic        keypad_event,
   input  wire logic        cmp1_toggle_event,
   input  wire logic        timer1_overflow_event,
   input  wire logic        cmp2_toggle_event,
   input  wire logic        uart_rx_done_event,
   input  wire logic        uart_tx_done_event,
   input  wire logic        brake_event,
   input  wire logic        core_last_cycle,
   input  wire logic        core_cfg_write,
   input  wire logic        core_reti,
   input  wire logic        power_down,
   output logic             hw_vector_call,
   output logic             call_busy,
   output ilc_vector_t      call_vector,
   output ilc_level_t       call_level,
   output logic [3:0]       in_service,
   output logic             wake_req
);
   localparam logic [13*16-1:0] VEC_TABLE = `ILC_VEC_TABLE;

   typedef struct packed {
      logic [1:0]  phase;
      logic [13:0] flag;
      logic [12:0] en;
      logic        ea;
      logic [12:0] plo;
      logic [12:0] phi;
      logic [2:0]  ctrl;
      logic [3:0]  insvc;
      logic [12:0] pend_smp;
      ilc_call_e   st;
      logic [4:0]  call_cnt;
      logic        call_pulse;
      ilc_vector_t vector;
      ilc_level_t  lvl;
      logic [31:0] rdata;
      logic        err;
   } ilc_main_s;

   ilc_main_s q;
   ilc_main_s d;

   logic        c3_strobe;
   logic        apb_wr;
   logic        apb_setup;
   logic        flag_we;
   logic [1:0]  ext_flag;
   logic [1:0]  ext_ack;
   logic [1:0]  ext_tt;
   logic [13:0] flag_view;
   logic [12:0] hw_set;
   logic [12:0] src_pend;
   logic [12:0] src_req;
   logic        win_valid;
   ilc_idx_t    win_idx;
   ilc_level_t  win_level;
   logic        addr_ok;
   logic        issue;

   // pins are sampled in the third clock of each machine cycle
   assign c3_strobe = (q.phase == `ILC_C3_PHASE);
   assign apb_wr    = psel && penable && pwrite;
   assign apb_setup = psel && !penable;
   assign flag_we   = apb_wr && (paddr == `ILC_OFF_FLAG);
   assign ext_tt    = {q.ctrl[`ILC_CTRL_IT1], q.ctrl[`ILC_CTRL_IT0]};

   // one sampler per external pin, each with its own trigger type
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_ext
         ilc_ext_sampler u_smp (
            .pclk             (pclk),
            .presetn          (presetn),
            .pin              (g == 0 ? ext_irq_pin0 : ext_irq_pin1),
            .c3_strobe        (c3_strobe),
            .trigger_type     (ext_tt[g]),
            .sw_we            (flag_we),
            .sw_val           (pwdata[g == 0 ? `ILC_SRC_EXT0
                                             : `ILC_SRC_EXT1]),
            .hw_ack           (ext_ack[g]),
            .ext_request_flag (ext_flag[g])
         );
      end
   endgenerate

   // Hardware event inputs lined up by source index
   always_comb
   begin
      hw_set = 13'h0000;
      hw_set[1]  = bod_event;
      hw_set[2]  = twi_status_event;
      hw_set[3]  = conv_done_event;
      hw_set[4]  = wdog_timeout_event;
      hw_set[5]  = timer0_overflow_event;
      hw_set[7]  = keypad_event;
      hw_set[8]  = cmp1_toggle_event;
      hw_set[9]  = timer1_overflow_event;
      hw_set[10] = cmp2_toggle_event;
      hw_set[11] = uart_rx_done_event;
      hw_set[12] = brake_event;
   end

   always_comb
   begin
      flag_view = q.flag;
      flag_view[`ILC_SRC_EXT0] = ext_flag[0];
      flag_view[`ILC_SRC_EXT1] = ext_flag[1];
   end

   // receive and transmit share one serial request
   always_comb
   begin
      src_pend = q.pend_smp;
   end

   // individual enables gated by the global enable
   // two-wire request also needs global enable
   assign src_req = src_pend & q.en & {13{q.ea}};

   ilc_prio_arb u_arb (
      .req            (src_req),
      .prio_low_bits  (q.plo),
      .prio_high_bits (q.phi),
      .insvc          (q.insvc),
      .win_valid      (win_valid),
      .win_idx        (win_idx),
      .win_level      (win_level)
   );

   // call only in the instruction's last cycle and not when it
   // rewrites enable or priority state
   assign issue = (q.st == ILC_POLL) && (q.phase == `ILC_C4_PHASE)
                  && win_valid && core_last_cycle && !core_cfg_write;

   // edge-mode pin flags acknowledged on entry
   assign ext_ack[0] = issue && (win_idx == 4'(`ILC_SRC_EXT0));
   assign ext_ack[1] = issue && (win_idx == 4'(`ILC_SRC_EXT1));

   always_comb
   begin
      unique case (paddr)
         `ILC_OFF_FLAG,
         `ILC_OFF_ENABLE,
         `ILC_OFF_PRIO_LO,
         `ILC_OFF_PRIO_HI,
         `ILC_OFF_CTRL,
         `ILC_OFF_STATUS: addr_ok = 1'b1;
         default:         addr_ok = 1'b0;
      endcase
   end

   always_comb
   begin
      d = q;
      d.phase      = q.phase + 2'h1;
      d.call_pulse = 1'b0;

      // flags are snapshot at the first clock and resolved
      // through the rest of the same machine cycle
      if (q.phase == 2'h0)
      begin
         d.pend_smp = flag_view[12:0];
         d.pend_smp[`ILC_SRC_SER] = flag_view[`ILC_SRC_SER]
                                    | flag_view[`ILC_TX_FLAG_BIT];
      end

      // software write sets or clears any flag; a level-mode pin flag only takes a set, for one clock, then follows its pin
      if (flag_we)
      begin
         d.flag = pwdata[13:0];
      end
      // timer flags cleared by the vectored entry
      if (issue && (win_idx == 4'(`ILC_SRC_TMR0)))
      begin
         d.flag[`ILC_SRC_TMR0] = 1'b0;
      end
      if (issue && (win_idx == 4'(`ILC_SRC_TMR1)))
      begin
         d.flag[`ILC_SRC_TMR1] = 1'b0;
      end
      // serial flags have no hardware clear; events win over clears
      d.flag[12:0] = d.flag[12:0] | hw_set;
      d.flag[`ILC_TX_FLAG_BIT] = d.flag[`ILC_TX_FLAG_BIT]
                                 | uart_tx_done_event;
      // External pin flags live in the samplers
      d.flag[`ILC_SRC_EXT0] = 1'b0;
      d.flag[`ILC_SRC_EXT1] = 1'b0;

      if (apb_wr)
      begin
         unique case (paddr)
            `ILC_OFF_ENABLE:
            begin
               d.en = pwdata[12:0];
               d.ea = pwdata[`ILC_EA_BIT];
            end
            `ILC_OFF_PRIO_LO: d.plo  = pwdata[12:0];
            `ILC_OFF_PRIO_HI: d.phi  = pwdata[12:0];
            `ILC_OFF_CTRL:    d.ctrl = pwdata[2:0];
            default:          d.err  = q.err;
         endcase
      end

      // Read data and error are latched in setup so that the access
      // phase completes with no wait state
      if (apb_setup)
      begin
         d.err   = !addr_ok;
         d.rdata = 32'h0000_0000;
         unique case (paddr)
            `ILC_OFF_FLAG:    d.rdata[13:0] = flag_view;
            `ILC_OFF_ENABLE:
            begin
               d.rdata[12:0] = q.en;
               d.rdata[`ILC_EA_BIT] = q.ea;
            end
            `ILC_OFF_PRIO_LO: d.rdata[12:0] = q.plo;
            `ILC_OFF_PRIO_HI: d.rdata[12:0] = q.phi;
            `ILC_OFF_CTRL:    d.rdata[2:0]  = q.ctrl;
            `ILC_OFF_STATUS:
            begin
               d.rdata[3:0]   = q.insvc;
               d.rdata[4]     = (q.st == ILC_CALL);
               d.rdata[31:16] = q.vector;
            end
            default:          d.rdata = 32'h0000_0000;
         endcase
      end

      // return drops the highest active level; a call in the same
      // cycle is applied after the return, so the called level stays set
      if (core_reti)
      begin
         if (q.insvc[3])
         begin
            d.insvc[3] = 1'b0;
         end
         else if (q.insvc[2])
         begin
            d.insvc[2] = 1'b0;
         end
         else if (q.insvc[1])
         begin
            d.insvc[1] = 1'b0;
         end
         else
         begin
            d.insvc[0] = 1'b0;
         end
      end

      unique case (q.st)
         ILC_POLL:
         begin
            if (issue)
            begin
               // vector chosen from the fixed table
               d.vector = VEC_TABLE[16*win_idx +: 16];
               d.lvl    = win_level;
               d.insvc[win_level] = 1'b1;
               d.call_pulse = 1'b1;
               d.st       = ILC_CALL;
               d.call_cnt = 5'(`ILC_CALL_CLKS - 1);
            end
         end
         ILC_CALL:
         begin
            // call occupies four machine cycles, then polling resumes
            // keeps total response inside twelve machine cycles
            if (q.call_cnt == 5'h00)
            begin
               d.st = ILC_POLL;
            end
            else
            begin
               d.call_cnt = q.call_cnt - 5'h01;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q.phase      <= 2'h0;
         q.flag       <= `ILC_RST_FLAG;
         q.en         <= `ILC_RST_EN;
         q.ea         <= 1'b0;
         q.plo        <= `ILC_RST_PRIO;
         q.phi        <= `ILC_RST_PRIO;
         q.ctrl       <= `ILC_RST_CTRL;
         q.insvc      <= 4'h0;
         q.pend_smp   <= 13'h0000;
         q.st         <= ILC_POLL;
         q.call_cnt   <= 5'h00;
         q.call_pulse <= 1'b0;
         q.vector     <= 16'h0000;
         q.lvl        <= 2'h0;
         q.rdata      <= 32'h0000_0000;
         q.err        <= 1'b0;
      end
      else
      begin
         q <= d;
      end
   end

   assign pready         = 1'b1;
   assign prdata         = q.rdata;
   assign pslverr        = q.err && psel && penable;
   assign hw_vector_call = q.call_pulse;
   assign call_busy      = (q.st == ILC_CALL);
   assign call_vector    = q.vector;
   assign call_level     = q.lvl;
   assign in_service     = q.insvc;

   // serial excluded from wakeup; conversion wakes only on RC
   logic [12:0] wake_mask;
   always_comb
   begin
      wake_mask = `ILC_WAKE_MASK;
      wake_mask[`ILC_SRC_ADC] = q.ctrl[`ILC_CTRL_ADC_RC];
   end
   assign wake_req = power_down && |(src_pend & q.en & wake_mask);
endmodule

// *** ilc_irq_ctrl_bench.sv ***
`timescale 1ns/1ns
module ilc_irq_ctrl_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [13:0] ev;
   logic        pin0, pin1, pdn, call, busy, wake, last, cfgw, reti, err;
   logic [1:0]  hold, lvl;
   logic [15:0] vec;
   logic [3:0]  insvc;
   logic [7:0]  svc_len;
   int          fail_count, checks, ncall;
   logic [15:0] vt [14] = '{16'h0003, 16'h004b, 16'h0033, 16'h005b,
      16'h0053, 16'h000b, 16'h0013, 16'h003b, 16'h0063, 16'h001b,
      16'h0043, 16'h0023, 16'h0073, 16'h0023};
   ilc_irq_ctrl ilc_irq_ctrl_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_irq_pin0(pin0),
      .ext_irq_pin1(pin1), .bod_event(ev[1]), .twi_status_event(ev[2]),
      .conv_done_event(ev[3]), .wdog_timeout_event(ev[4]),
      .timer0_overflow_event(ev[5]), .keypad_event(ev[7]),
      .cmp1_toggle_event(ev[8]), .timer1_overflow_event(ev[9]),
      .cmp2_toggle_event(ev[10]), .uart_rx_done_event(ev[11]),
      .uart_tx_done_event(ev[13]), .brake_event(ev[12]),
      .core_last_cycle(last), .core_cfg_write(cfgw), .core_reti(reti),
      .power_down(pdn), .hw_vector_call(call), .call_busy(busy),
      .call_vector(vec), .call_level(lvl), .in_service(insvc),
      .wake_req(wake));
   ilc_core_model ilc_core_model_inst (
      .pclk(pclk), .presetn(presetn), .hw_vector_call(call),
      .call_busy(busy), .stall(hold[0]), .cfg_wr(hold[1]),
      .svc_len(svc_len), .core_last_cycle(last), .core_cfg_write(cfgw),
      .core_reti(reti));
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk)
      if (call === 1'b1)
         ncall <= ncall + 1;
   task automatic close_out;
      if (fail_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic lost;
      fail_count++;
      $display("ERROR %0t wait limit reached", $time);
      close_out();
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (n == 16)
         lost();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wcall(input logic [15:0] exp, input int lim);
      int n;
      for (n = 0; n < lim; n++)
      begin
         @(posedge pclk);
         if (call === 1'b1)
            break;
      end
      if (n == lim)
         lost();
      cmp({16'h0000, vec}, {16'h0000, exp});
   endtask
   task automatic wsvc(input logic [3:0] e);
      int n;
      for (n = 0; n < 400; n++)
      begin
         @(posedge pclk);
         if (insvc === e)
            break;
      end
      if (n == 400)
         lost();
   endtask
   task automatic nocall;
      int c;
      c = ncall;
      repeat (60) @(posedge pclk);
      cmp(ncall, c);
   endtask
   task automatic t_reset;
      for (int a = 0; a < 6; a++)
      begin
         apb(1'b0, 12'(a * 4), 32'h0);
         cmp(rd, 32'h0);
      end
      apb(1'b0, 12'h018, 32'h0);
      cmp({rd[30:0], err}, 32'h1);
   endtask
   task automatic t_sources;
      apb(1'b1, 12'h010, 32'h3);
      apb(1'b1, 12'h004, 32'h9fff);
      for (int i = 0; i < 14; i++)
      begin
         if (i == 0 || i == 6)
            apb(1'b1, 12'h000, 32'h1 << i);
         else
         begin
            ev[i] <= 1'b1;
            @(posedge pclk);
            ev[i] <= 1'b0;
         end
         wcall(vt[i], 48);
         apb(1'b0, 12'h000, 32'h0);
         cmp(rd[i], !(i inside {0, 5, 6, 9}));
         apb(1'b1, 12'h000, 32'h0);
         wsvc(4'h0);
      end
   endtask
   task automatic t_mask;
      apb(1'b1, 12'h004, 32'h1fff);
      apb(1'b1, 12'h000, 32'h1000);
      nocall();
      apb(1'b1, 12'h004, 32'h8fff);
      nocall();
      apb(1'b1, 12'h004, 32'h9fff);
      wcall(16'h0073, 48);
      apb(1'b1, 12'h000, 32'h0);
      wsvc(4'h0);
   endtask
   task automatic t_prio;
      apb(1'b1, 12'h000, 32'h180);
      wcall(16'h003b, 48);
      apb(1'b1, 12'h000, 32'h100);
      wcall(16'h0063, 120);
      apb(1'b1, 12'h000, 32'h0);
      wsvc(4'h0);
      svc_len <= 8'h96;
      apb(1'b1, 12'h008, 32'h100);
      apb(1'b1, 12'h00c, 32'h100);
      apb(1'b1, 12'h000, 32'h80);
      wcall(16'h003b, 48);
      apb(1'b1, 12'h000, 32'h100);
      wcall(16'h0063, 48);
      cmp(lvl, 2'h3);
      apb(1'b0, 12'h014, 32'h0);
      cmp(rd[3:0], 4'h9);
      // Clear first so the return does not re-raise the same request
      apb(1'b1, 12'h000, 32'h0);
      wsvc(4'h1);
      svc_len <= 8'h04;
      apb(1'b1, 12'h008, 32'h0);
      apb(1'b1, 12'h00c, 32'h0);
      wsvc(4'h0);
   endtask
   task automatic t_ext;
      apb(1'b1, 12'h010, 32'h2);
      pin0 <= 1'b0;
      wcall(16'h0003, 48);
      wcall(16'h0003, 120);
      pin0 <= 1'b1;
      wsvc(4'h0);
      pin1 <= 1'b0;
      wcall(16'h0013, 48);
      apb(1'b0, 12'h000, 32'h0);
      cmp(rd[6], 1'b0);
      wsvc(4'h0);
      nocall();
      pin1 <= 1'b1;
   endtask
   task automatic t_hold;
      for (int m = 1; m < 3; m++)
      begin
         hold <= 2'(m);
         apb(1'b1, 12'h000, 32'h80);
         nocall();
         hold <= 2'h0;
         wcall(16'h003b, 48);
         apb(1'b1, 12'h000, 32'h0);
         wsvc(4'h0);
      end
   endtask
   task automatic t_wake;
      logic [13:0] f [4] = '{14'h800, 14'h80, 14'h8, 14'h8};
      hold <= 2'h1;
      pdn <= 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         apb(1'b1, 12'h010, {29'h0, k == 3, 2'h0});
         apb(1'b1, 12'h000, {18'h0, f[k]});
         // Wakeup sees flags only after the next machine-cycle snapshot
         repeat (5) @(posedge pclk);
         cmp(wake, k[0]);
      end
      apb(1'b1, 12'h000, 32'h0);
   endtask
   initial
   begin
      {psel, penable, pwrite, pdn, hold, paddr, pwdata, ev} = '0;
      {pin0, pin1} = 2'b11;
      svc_len = 8'h04;
      presetn = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_sources();
      t_mask();
      t_prio();
      t_ext();
      t_hold();
      t_wake();
      close_out();
   end
endmodule

// *** ilc_irq_ctrl_monitor.sv ***
`timescale 1ns/1ns
module ilc_irq_ctrl_monitor
   import ilc_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        core_last_cycle,
   input wire logic        core_cfg_write,
   input wire logic        core_reti,
   input wire logic        hw_vector_call,
   input wire logic        call_busy,
   input wire ilc_vector_t call_vector,
   input wire ilc_level_t  call_level,
   input wire logic [3:0]  in_service
);
   logic [1:0] ph_q;
   logic [3:0] top;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         ph_q <= 2'h0;
      else
         ph_q <= ph_q + 2'h1;
   // One-hot of the highest level in service
   always_comb
   begin
      top = 4'h0;
      for (int i = 0; i < 4; i++)
         if (in_service[i])
            top = 4'h1 << i;
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_busy_run;
      call_busy [*8];
   endsequence
   sequence s_busy_done;
      ##[15:17] !call_busy;
   endsequence
   chk_call_pulse:
      assert property (hw_vector_call |=> !hw_vector_call)
      else $error("call pulse too long");
   chk_busy_hold:
      assert property (hw_vector_call |=> s_busy_run)
      else $error("busy dropped early");
   chk_busy_end:
      assert property (hw_vector_call |-> s_busy_done)
      else $error("busy not four machine cycles");
   chk_busy_block:
      assert property (call_busy && $past(call_busy) |-> !hw_vector_call)
      else $error("call while busy");
   chk_call_gate:
      assert property (hw_vector_call |->
         $past(core_last_cycle) && !$past(core_cfg_write))
      else $error("call outside last cycle");
   chk_call_phase:
      assert property (hw_vector_call |-> ph_q == 2'h0)
      else $error("call off machine cycle");
   chk_prio_rule:
      assert property (hw_vector_call |-> in_service[call_level] &&
         (($past(in_service) >> call_level) == 4'h0))
      else $error("call at or below level in service");
   chk_reti_top:
      assert property (core_reti |=> (in_service & $past(top)) == 4'h0)
      else $error("return left top level set");
   chk_vec_table:
      assert property (hw_vector_call |-> call_vector inside {16'h0003,
         16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h0033, 16'h003b,
         16'h0043, 16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h0073})
      else $error("vector not in table");
   chk_vec_hold:
      assert property (!hw_vector_call |-> $stable(call_vector))
      else $error("vector changed without call");
endmodule
bind ilc_irq_ctrl ilc_irq_ctrl_monitor ilc_irq_ctrl_monitor_inst (
   .pclk(pclk), .presetn(presetn), .core_last_cycle(core_last_cycle),
   .core_cfg_write(core_cfg_write), .core_reti(core_reti),
   .hw_vector_call(hw_vector_call), .call_busy(call_busy),
   .call_vector(call_vector), .call_level(call_level),
   .in_service(in_service)
);

// *** ilc_pkg.sv ***
package ilc_pkg;
   typedef logic [1:0]  ilc_level_t;
   typedef logic [15:0] ilc_vector_t;
   typedef logic [3:0]  ilc_idx_t;
   typedef enum logic [0:0] {ILC_POLL, ILC_CALL} ilc_call_e;
endpackage

// *** ilc_prio_arb.sv ***
`timescale 1ns/1ns
`include "ilc_defs.svh"
module ilc_prio_arb
   import ilc_pkg::*;
(
   input  wire logic [12:0] req,
   input  wire logic [12:0] prio_low_bits,
   input  wire logic [12:0] prio_high_bits,
   input  wire logic [3:0]  insvc,
   output logic             win_valid,
   output ilc_idx_t         win_idx,
   output ilc_level_t       win_level
);
   ilc_level_t lvl;
   logic [2:0] floor_lvl;

   always_comb
   begin
      floor_lvl = 3'h0;
      for (int l = 0; l < 4; l++)
      begin
         if (insvc[l])
         begin
            floor_lvl = 3'(l + 1);
         end
      end
      win_valid = 1'b0;
      win_idx   = 4'h0;
      win_level = 2'h0;
      lvl       = 2'h0;
      // lower index wins ties; scan from bottom rank
      for (int i = `ILC_NSRC - 1; i >= 0; i--)
      begin
         lvl = {prio_high_bits[i], prio_low_bits[i]};
         if (req[i] && ({1'b0, lvl} >= floor_lvl)
             && (!win_valid || lvl >= win_level))
         begin
            win_valid = 1'b1;
            win_idx   = 4'(i);
            win_level = lvl;
         end
      end
      if (win_valid && floor_lvl != 3'h0
          && {1'b0, win_level} < floor_lvl)
      begin
         win_valid = 1'b0;
      end
   end
endmodule
